// [common/pds_pkg.sv]
// Behaviour
// - each of seven outputs owns its own 3-bit shutdown slot field
// - the sequencer only takes outputs down, the reverse of start-up
// - after reset every shutdown slot equals that output's programmed startup slot
// - outputs switch off from the highest slot value down to the lowest
// - host slot writes take effect only while the system is on
// - startup order never comes from the shutdown slots; block enables outputs only in reset, which sets all seven on
// - all slots zero: every output switches off together in one step
package pds_pkg;

  localparam int NUM_OUT = 7;
  localparam int SLOT_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  typedef logic [SLOT_W-1:0] pds_slot_t;
  typedef logic [NUM_OUT-1:0] pds_mask_t;
  typedef logic [ADDR_W-1:0] pds_addr_t;
  typedef logic [DATA_W-1:0] pds_data_t;

  // output order inside every mask and slot vector
  localparam int IDX_BUCK_ONE = 0;
  localparam int IDX_BUCK_TWO = 1;
  localparam int IDX_BUCK_THREE = 2;
  localparam int IDX_LINEAR_REG_ONE = 3;
  localparam int IDX_LINEAR_REG_TWO = 4;
  localparam int IDX_LINEAR_REG_THREE = 5;
  localparam int IDX_MEMORY_REFERENCE_OUT = 6;

  // register map
  localparam pds_addr_t BUCK_ONE_SHUTDOWN_SLOT = 8'h5F;
  localparam pds_addr_t BUCK_TWO_SHUTDOWN_SLOT = 8'h60;
  localparam pds_addr_t BUCK_THREE_SHUTDOWN_SLOT = 8'h61;
  localparam pds_addr_t LINEAR_REG_ONE_SHUTDOWN_SLOT = 8'h62;
  localparam pds_addr_t LINEAR_REG_TWO_SHUTDOWN_SLOT = 8'h63;
  localparam pds_addr_t LINEAR_REG_THREE_SHUTDOWN_SLOT = 8'h64;
  localparam pds_addr_t MEMORY_REFERENCE_SHUTDOWN_SLOT = 8'h65;

  localparam pds_addr_t SLOT_ADDR_TBL [NUM_OUT] = '{
    BUCK_ONE_SHUTDOWN_SLOT, BUCK_TWO_SHUTDOWN_SLOT, BUCK_THREE_SHUTDOWN_SLOT,
    LINEAR_REG_ONE_SHUTDOWN_SLOT, LINEAR_REG_TWO_SHUTDOWN_SLOT,
    LINEAR_REG_THREE_SHUTDOWN_SLOT, MEMORY_REFERENCE_SHUTDOWN_SLOT
  };

  // field layout and reset values
  localparam int SLOT_LSB = 0;
  localparam pds_slot_t SLOT_RESET = 3'h0;
  localparam logic [DATA_W-SLOT_W-1:0] UNUSED_BITS = 5'h00;
  localparam pds_data_t DATA_ZERO = 8'h00;
  localparam pds_mask_t ALL_ON = 7'h7F;
  localparam pds_mask_t ALL_OFF = 7'h00;

  // gap between two slot steps
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_DELAY_NS = 2000;
  localparam int STEP_DELAY_CYC = (STEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 12;
  typedef logic [DLY_W-1:0] pds_dly_t;
  localparam pds_dly_t DLY_ZERO = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STEP,
    ST_DELAY
  } pds_state_e;

endpackage

// [rtl/pds_slot_scan.sv]
`timescale 1ns/1ps
module pds_slot_scan (
  // slot table and outputs still on
  input wire logic [pds_pkg::NUM_OUT-1:0][pds_pkg::SLOT_W-1:0] slot_i,
  input wire pds_pkg::pds_mask_t on_i,
  // highest slot among outputs still on
  output pds_pkg::pds_slot_t top_slot_o,
  output pds_pkg::pds_mask_t match_o,
  output logic any_on_o
);
  import pds_pkg::*;

  always_comb begin
    top_slot_o = SLOT_RESET;
    match_o = ALL_OFF;
    any_on_o = |on_i;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (on_i[i] && slot_i[i] > top_slot_o) begin
        top_slot_o = slot_i[i];
      end
    end
    // every output on the top slot goes in the same step
    for (int i = 0; i < NUM_OUT; i++) begin
      match_o[i] = on_i[i] && (slot_i[i] == top_slot_o);
    end
  end

endmodule

// [rtl/pds_sequencer.sv]
`timescale 1ns/1ps
module pds_sequencer #(
  parameter int STEP_DELAY = pds_pkg::STEP_DELAY_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // system state and startup configuration
  input wire logic system_on_i,
  input wire logic pwrdn_start_i,
  input wire logic [pds_pkg::NUM_OUT-1:0][pds_pkg::SLOT_W-1:0] startup_slot_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pds_pkg::pds_addr_t reg_addr_i,
  input wire pds_pkg::pds_data_t reg_wdata_i,
  output pds_pkg::pds_data_t reg_rdata_o,
  output logic reg_rvalid_o,
  // rail control
  output pds_pkg::pds_mask_t rail_enable_o,
  output logic seq_busy_o,
  output logic seq_done_o
);
  import pds_pkg::*;

  function automatic int addr_to_idx(input pds_addr_t a);
    int idx;
    idx = NUM_OUT;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (a == SLOT_ADDR_TBL[i]) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  logic [NUM_OUT-1:0][SLOT_W-1:0] slot_r, slot_nxt;
  logic reload_r, reload_nxt;
  pds_data_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  pds_state_e state_r, state_nxt;
  pds_mask_t en_r, en_nxt;
  pds_slot_t cur_slot_r, cur_slot_nxt;
  pds_dly_t dly_r, dly_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  int wr_idx;
  int rd_idx;
  logic wr_ok;
  logic all_zero;
  pds_slot_t top_slot;
  pds_mask_t match_mask;
  logic any_on;

  assign wr_idx = addr_to_idx(reg_addr_i);
  assign rd_idx = addr_to_idx(reg_addr_i);
  // writes only land in an on state and never under a running shutdown
  assign wr_ok = reg_wr_i && system_on_i && !reload_r && (state_r == ST_IDLE);
  assign all_zero = ~|slot_r;

  pds_slot_scan u_scan (
    .slot_i(slot_r),
    .on_i(en_r),
    .top_slot_o(top_slot),
    .match_o(match_mask),
    .any_on_o(any_on)
  );

  // register file
  always_comb begin
    slot_nxt = slot_r;
    reload_nxt = 1'b0;
    rdata_nxt = DATA_ZERO;
    rvalid_nxt = reg_rd_i;
    if (reload_r) begin
      // startup slots are sampled one cycle after reset release, not during it
      slot_nxt = startup_slot_i;
    end else if (wr_ok && wr_idx < NUM_OUT) begin
      slot_nxt[wr_idx] = reg_wdata_i[SLOT_LSB +: SLOT_W];
    end
    if (reg_rd_i && rd_idx < NUM_OUT) begin
      rdata_nxt = {UNUSED_BITS, slot_r[rd_idx]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      slot_r <= {NUM_OUT{SLOT_RESET}};
      reload_r <= 1'b1;
      rdata_r <= DATA_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      reload_r <= reload_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // shutdown sequencer
  always_comb begin
    state_nxt = state_r;
    en_nxt = en_r;
    cur_slot_nxt = cur_slot_r;
    dly_nxt = dly_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pwrdn_start_i && !reload_r) begin
          if (all_zero || !any_on) begin
            en_nxt = ALL_OFF;
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_STEP;
          end
        end
      end
      ST_STEP: begin
        // only clears enables; bringing rails up belongs to the startup logic
        en_nxt = en_r & ~match_mask;
        cur_slot_nxt = top_slot;
        dly_nxt = DLY_W'(STEP_DELAY - 1);
        state_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (dly_r != DLY_ZERO) begin
          dly_nxt = dly_r - 1'b1;
        end else if (any_on) begin
          state_nxt = ST_STEP;
        end else begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      en_r <= ALL_ON;
      cur_slot_r <= SLOT_RESET;
      dly_r <= DLY_ZERO;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_r <= en_nxt;
      cur_slot_r <= cur_slot_nxt;
      dly_r <= dly_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign rail_enable_o = en_r;
  assign seq_busy_o = busy_r;
  assign seq_done_o = done_r;

  // checking helpers
  pds_slot_t last_slot_r;
  logic have_last_r;
  pds_mask_t ge_mask;

  always_ff @(posedge clock_i) begin
    if (rst_i || state_r == ST_IDLE) begin
      have_last_r <= 1'b0;
      last_slot_r <= SLOT_RESET;
    end else if (state_r == ST_STEP) begin
      have_last_r <= 1'b1;
      last_slot_r <= top_slot;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      ge_mask[i] = (slot_r[i] >= cur_slot_r);
    end
  end

  property p_slot_width;
    @(posedge clock_i) disable iff (rst_i)
    reg_rvalid_o |-> (reg_rdata_o[DATA_W-1:SLOT_W] == UNUSED_BITS);
  endproperty
  a_slot_width: assert property (p_slot_width) else $error("unused slot bits not zero");

  property p_never_enable;
    @(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> ((rail_enable_o & ~$past(rail_enable_o)) == ALL_OFF);
  endproperty
  a_never_enable: assert property (p_never_enable) else $error("sequencer raised a rail");

  property p_reload;
    @(posedge clock_i) disable iff (rst_i)
    // reset is sampled too, so the release edge itself starts no attempt
    (reload_r && !rst_i) |=> (slot_r == $past(startup_slot_i));
  endproperty
  a_reload: assert property (p_reload) else $error("slots not loaded from startup");

  property p_descend;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == ST_STEP && have_last_r) |-> (top_slot < last_slot_r);
  endproperty
  a_descend: assert property (p_descend) else $error("slot order not descending");

  property p_write_taken;
    @(posedge clock_i) disable iff (rst_i)
    (wr_ok && wr_idx == IDX_BUCK_TWO)
      |=> (slot_r[IDX_BUCK_TWO] == $past(reg_wdata_i[SLOT_LSB +: SLOT_W]));
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("slot write lost");

  property p_write_refused;
    @(posedge clock_i) disable iff (rst_i)
    (!system_on_i && !reload_r) |=> $stable(slot_r);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("slot changed while off");

  property p_bypass;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == ST_IDLE && pwrdn_start_i && !reload_r && all_zero)
      |=> (rail_enable_o == ALL_OFF) && seq_done_o && !seq_busy_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not switch all off");

  property p_group_off;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == ST_DELAY) |-> ((rail_enable_o & ge_mask) == ALL_OFF);
  endproperty
  a_group_off: assert property (p_group_off) else $error("slot group not fully off");

  property p_gap;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == ST_STEP) |=> (state_r == ST_DELAY) && (dly_r == DLY_W'(STEP_DELAY - 1));
  endproperty
  a_gap: assert property (p_gap) else $error("step delay not loaded");

  property p_gap_hold;
    @(posedge clock_i) disable iff (rst_i)
    (state_r == ST_DELAY && dly_r != DLY_ZERO) |=> (state_r == ST_DELAY) && $stable(rail_enable_o);
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("rail moved during delay");

endmodule

// [test/pds_host_model.sv]
`timescale 1ns/1ps
module pds_host_model (
  // clock and read answer
  input wire logic clock_i,
  input wire pds_pkg::pds_data_t reg_rdata_i,
  input wire logic reg_rvalid_i,
  // register requests
  output logic reg_wr_o,
  output logic reg_rd_o,
  output pds_pkg::pds_addr_t reg_addr_o,
  output pds_pkg::pds_data_t reg_wdata_o
);
  import pds_pkg::*;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // address and data are inverted once released, so stale values never pass
  task automatic wr(input pds_addr_t a, input pds_data_t d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input pds_addr_t a, output pds_data_t d, output logic v);
    @(posedge clock_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule

// [test/pds_sequencer_tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
module pds_sequencer_tb_top;
  import pds_pkg::*;
  typedef logic [NUM_OUT-1:0][SLOT_W-1:0] pds_tbl_t;
  localparam int D = 2;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic system_on = 1'b1;
  logic start = 1'b0;
  pds_tbl_t su = '0;
  logic wr, rd, rvalid, busy, done;
  pds_addr_t addr;
  pds_data_t wdata, rdata;
  pds_mask_t rail;
  int mismatches = 0;
  int num_checks = 0;
  bit timed_out = 1'b0;
  always #10 clock_i = ~clock_i;
  pds_sequencer #(.STEP_DELAY(D)) pds_sequencer_i (.clock_i(clock_i), .rst_i(rst_i),
    .system_on_i(system_on), .pwrdn_start_i(start), .startup_slot_i(su), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .rail_enable_o(rail), .seq_busy_o(busy), .seq_done_o(done));
  pds_host_model pds_host_model_i (.clock_i(clock_i), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // drop every still-on output that holds the highest slot
  function automatic pds_mask_t next_mask(pds_mask_t m, pds_tbl_t s);
    pds_slot_t top;
    top = 3'h0;
    for (int i = 0; i < NUM_OUT; i++) if (m[i] && s[i] > top) top = s[i];
    for (int i = 0; i < NUM_OUT; i++) if (s[i] == top) m[i] = 1'b0;
    return m;
  endfunction
  function automatic int ndist(pds_tbl_t s);
    logic [7:0] seen;
    seen = 8'h00;
    for (int i = 0; i < NUM_OUT; i++) seen[s[i]] = 1'b1;
    return $countones(seen);
  endfunction
  task automatic chk_regs(input pds_tbl_t s);
    pds_data_t d;
    logic v;
    for (int i = 0; i < NUM_OUT; i++) begin
      pds_host_model_i.rd(SLOT_ADDR_TBL[i], d, v);
      `CHK(v, 1'b1)
      `CHK(d, {5'h00, s[i]})
    end
  endtask
  task automatic run_down(input pds_tbl_t s);
    pds_mask_t prev;
    int steps;
    int n;
    prev = ALL_ON;
    steps = 0;
    @(posedge clock_i);
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    #1;
    if (s == '0) begin
      `CHK(rail, ALL_OFF)
      `CHK(done, 1'b1)
    end else begin
      `CHK(busy, 1'b1)
      for (n = 0; n < 1000; n++) begin
        if (rail !== prev) begin
          `CHK(rail, next_mask(prev, s))
          prev = rail;
          steps++;
        end
        if (done === 1'b1) break;
        @(posedge clock_i);
        #1;
      end
      if (n == 1000) begin
        mismatches++;
        timed_out = 1'b1;
      end
      `CHK(steps, ndist(s))
      `CHK(n, ndist(s) * (D + 1))
      `CHK(busy, 1'b0)
      `CHK(rail, ALL_OFF)
    end
  endtask
  initial begin
    pds_data_t d;
    logic v;
    int k;
    pds_tbl_t cur;
    void'($urandom(21));
    // round 0 all slots zero, round 1 all equal, then random tables
    for (int r = 0; r < 6; r++) begin
      @(posedge clock_i);
      rst_i <= 1'b1;
      for (int i = 0; i < NUM_OUT; i++) begin
        su[i] <= (r == 0) ? 3'h0 : (r == 1) ? 3'h7 : 3'($urandom_range(7, 0));
      end
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      `CHK(rail, ALL_ON)
      cur = su;
      chk_regs(cur);
      pds_host_model_i.rd(8'h66, d, v);
      `CHK(d, DATA_ZERO)
      if (r > 1) begin
        // round 2 always rewrites buck_two so its write check is reached
        k = (r == 2) ? IDX_BUCK_TWO : $urandom_range(NUM_OUT - 1, 0);
        d = 8'($urandom);
        @(posedge clock_i);
        system_on <= 1'b0;
        pds_host_model_i.wr(SLOT_ADDR_TBL[k], d);
        chk_regs(cur);
        @(posedge clock_i);
        system_on <= 1'b1;
        pds_host_model_i.wr(SLOT_ADDR_TBL[k], d);
        cur[k] = d[2:0];
        chk_regs(cur);
      end
      run_down(cur);
      if (timed_out) break;
      $display("round %0d done", r);
    end
    end_sim();
  end
endmodule
